// file: core/tscr_pkg.sv
/*
  tscr_pkg: register offsets, field positions, reset values, lock byte
  sequences and sizes for the touch sense configuration register bank.
  Assumes nothing of its surroundings; imported by every design file.
*/
package tscr_pkg;

  localparam int unsigned SENSORS    = 2;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned COUNT_W    = 16;
  localparam int unsigned SUM_W      = 20;

  // register offsets
  localparam logic [7:0] OFS_FILTER_CTRL  = 8'h56;
  localparam logic [7:0] OFS_SCAN_ORDER_0 = 8'h5c;
  localparam logic [7:0] OFS_SCAN_ORDER_1 = 8'h5d;
  localparam logic [7:0] OFS_THRESHOLD_0  = 8'h66;
  localparam logic [7:0] OFS_THRESHOLD_1  = 8'h67;
  localparam logic [7:0] OFS_CHARGE_0     = 8'h70;
  localparam logic [7:0] OFS_CHARGE_1     = 8'h71;
  localparam logic [7:0] OFS_ADDR_GUARD   = 8'h79;
  localparam logic [7:0] OFS_BUS_ADDRESS  = 8'h7c;

  // filter control, lock flag and scan position field positions
  localparam int unsigned BIT_BASELINE_CLEAR = 7;
  localparam int unsigned BIT_DROP_ON_BUS    = 5;
  localparam int unsigned BIT_AVG_ENABLE     = 4;
  localparam int unsigned BIT_ORDER_HI       = 1;
  localparam int unsigned BIT_ORDER_LO       = 0;
  localparam int unsigned BIT_LOCK_FLAG      = 0;
  localparam int unsigned BIT_SCAN_POS       = 0;

  // values after reset, and the zero charge current value
  localparam logic [7:0] RST_FILTER_CTRL  = 8'h20;
  localparam logic [7:0] RST_SCAN_ORDER_0 = 8'h00;
  localparam logic [7:0] RST_SCAN_ORDER_1 = 8'h01;
  localparam logic [7:0] RST_THRESHOLD    = 8'h64;
  localparam logic [7:0] RST_CHARGE       = 8'h0a;
  localparam logic [7:0] RST_BUS_ADDRESS  = 8'h00;
  localparam logic       RST_LOCK_FLAG    = 1'b0;
  localparam logic [7:0] CHARGE_ZERO      = 8'h00;

  // lock register byte sequences
  localparam logic [7:0] UNLOCK_BYTE_0 = 8'h3c;
  localparam logic [7:0] UNLOCK_BYTE_1 = 8'ha5;
  localparam logic [7:0] UNLOCK_BYTE_2 = 8'h69;
  localparam logic [7:0] LOCK_BYTE_0   = 8'h96;
  localparam logic [7:0] LOCK_BYTE_1   = 8'h5a;
  localparam logic [7:0] LOCK_BYTE_2   = 8'hc3;

  typedef enum logic [2:0] {
    TSCR_SEQ_IDLE  = 3'b000,
    TSCR_SEQ_UNL_1 = 3'b001,
    TSCR_SEQ_UNL_2 = 3'b011,
    TSCR_SEQ_LCK_1 = 3'b100,
    TSCR_SEQ_LCK_2 = 3'b110
  } tscr_seq_e;

  typedef logic [COUNT_W-1:0] tscr_count_t;

endpackage : tscr_pkg

// file: core/tscr_sample_if.sv
/*
  tscr_sample_if: one sensor's accepted raw sample stream plus the
  averaging settings, from the register bank to its averager.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface tscr_sample_if;
  import tscr_pkg::*;
  logic        valid;
  tscr_count_t count;
  logic        avg_en;
  logic [1:0]  order;
  logic        clear;

  modport src (output valid, output count, output avg_en, output order, output clear);
  modport dst (input valid, input count, input avg_en, input order, input clear);
endinterface : tscr_sample_if

// file: core/tscr_avg.sv
/*
  tscr_avg: averages one sensor's raw counts over 2, 4, 8 or 16 samples,
  or passes each sample through when averaging is off.
  Assumes samples arrive as single-cycle valid pulses on the interface.
*/
`timescale 1ns/1ps
module tscr_avg
  import tscr_pkg::*;
(
  input  wire logic        clk_in,     // system clock
  input  wire logic        rst_n_in,   // synchronous reset, active low
  input  wire logic        ce_in,      // clock enable
  tscr_sample_if.dst       smp,        // sample stream and settings
  output logic             valid_out,  // result strobe, one cycle
  output tscr_pkg::tscr_count_t count_out // averaged count
);
  import tscr_pkg::*;

  logic [SUM_W-1:0] sum_q;
  logic [3:0]       cnt_q;
  logic [3:0]       last_idx;
  logic [SUM_W-1:0] sum_new;
  logic [SUM_W-1:0] shifted;

  assign last_idx = 4'((5'd2 << smp.order) - 5'd1);
  assign sum_new  = sum_q + {4'h0, smp.count};
  assign shifted  = sum_new >> ({1'b0, smp.order} + 3'd1);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sum_q     <= '0;
      cnt_q     <= '0;
      valid_out <= 1'b0;
      count_out <= '0;
    end else if (ce_in) begin
      valid_out <= 1'b0;
      if (smp.clear || !smp.avg_en) begin
        sum_q <= '0;
        cnt_q <= '0;
      end
      if (smp.valid && !smp.avg_en) begin
        valid_out <= 1'b1;
        count_out <= smp.count;
      end else if (smp.valid && !smp.clear) begin
        if (cnt_q >= last_idx) begin
          valid_out <= 1'b1;
          count_out <= shifted[COUNT_W-1:0];
          sum_q     <= '0;
          cnt_q     <= '0;
        end else begin
          sum_q <= sum_new;
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  pass_through_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && smp.valid && !smp.avg_en |=> valid_out && count_out == $past(smp.count))
    else $error("sample not passed through with averaging off");

  pair_average_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && smp.avg_en && smp.order == 2'b00 && smp.valid && !smp.clear && cnt_q == 4'h0
    ##1 ce_in && smp.avg_en && smp.order == 2'b00 && smp.valid && !smp.clear
    |=> valid_out && count_out == 16'((32'($past(smp.count, 2)) + 32'($past(smp.count))) >> 1))
    else $error("two-sample average wrong");

endmodule : tscr_avg

// file: core/tscr_regs.sv
/*
  tscr_regs: configuration register bank of a one- or two-button touch
  controller: filter control, scan order, touch thresholds, charge current
  and the guarded bus address. Also drops, averages and classifies samples.
  Assumes the serial slave presents byte accesses on the register port,
  one per cycle, and that all inputs are synchronous to clk_in.
*/
// Behaviour
// - baseline clear bit resets baselines, self-clears
// - drop samples scanned during bus activity
// - average 2,4,8,16 samples by order field
// - sensors scanned in order of position bit
// - second sensor registers absent on one-button
// - per-sensor threshold, default 0x64, range 3-255; any byte is stored
// - per-sensor charge current, default 0x0a
// - charge current written zero becomes 10
// - lock state changes only on full sequence
// - 3c a5 69 unlocks address access
// - 96 5a c3 locks address access
// - lock register bit 0 reads lock state
// - address writes ignored while locked
// - new address used only after relocking
// - touch state uses threshold with hysteresis
`timescale 1ns/1ps
module tscr_regs
  import tscr_pkg::*;
#(
  parameter logic TWO_BUTTON = 1'b1  // 0 selects the one-button variant
) (
  input  wire logic                                   clk_in,             // clock
  input  wire logic                                   rst_n_in,           // sync reset, low
  input  wire logic                                   ce_in,              // clock enable
  input  wire logic [7:0]                             reg_addr_in,        // register offset
  input  wire logic [7:0]                             reg_wdata_in,       // write byte
  input  wire logic                                   reg_wr_in,          // write strobe
  input  wire logic                                   reg_rd_in,          // read strobe
  output logic [7:0]                                  reg_rdata_out,      // read byte
  output logic                                        reg_rvalid_out,     // read data valid
  input  wire logic                                   setup_mode_in,      // setup mode active
  input  wire logic                                   bus_active_in,      // serial bus busy
  input  wire logic                                   scan_start_in,      // scan begins
  input  wire logic                                   sample_valid_in,    // raw sample strobe
  input  wire logic                                   sample_sensor_in,   // sample's sensor
  input  wire tscr_pkg::tscr_count_t                  raw_count_in,       // raw count
  input  wire logic [tscr_pkg::SENSORS-1:0][15:0]     diff_count_in,      // difference counts
  input  wire logic [7:0]                             hysteresis_in,      // shared hysteresis
  output logic                                        baseline_clear_out, // clear all baselines
  output logic [tscr_pkg::SENSORS-1:0]                avg_valid_out,      // filtered strobe
  output logic [tscr_pkg::SENSORS-1:0][15:0]          avg_count_out,      // filtered counts
  output logic [tscr_pkg::SENSORS-1:0]                touch_active_out,   // sensor touched
  output logic                                        first_sensor_out,   // sensor scanned first
  output logic [tscr_pkg::SENSORS-1:0][7:0]           charge_current_out, // charge settings
  output logic [7:0]                                  bus_address_out,    // address in use
  output logic                                        address_locked_out  // address locked flag
);
  import tscr_pkg::*;

  logic [7:0]                filter_q;
  logic [SENSORS-1:0]        scan_order_q;
  logic [SENSORS-1:0][7:0]   threshold_q;
  logic [SENSORS-1:0][7:0]   charge_q;
  logic [7:0]                addr_pending_q;
  logic                      bus_seen_q;
  tscr_seq_e                 seq_q;
  logic                      lock_wr;
  logic                      sample_ok;
  logic [7:0]                rdata_d;
  logic [SENSORS-1:0]        exists;

  assign exists  = {TWO_BUTTON, 1'b1};
  assign lock_wr = ce_in && reg_wr_in && reg_addr_in == OFS_ADDR_GUARD;

  // filter control; the self-clearing bit lives one cycle
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      filter_q           <= RST_FILTER_CTRL;
      baseline_clear_out <= 1'b0;
    end else if (ce_in) begin
      baseline_clear_out <= 1'b0;
      filter_q[BIT_BASELINE_CLEAR] <= 1'b0;
      if (reg_wr_in && reg_addr_in == OFS_FILTER_CTRL) begin
        filter_q <= reg_wdata_in & 8'hb3;
        baseline_clear_out <= reg_wdata_in[BIT_BASELINE_CLEAR];
      end
    end
  end

  // per-sensor settings
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      scan_order_q <= {RST_SCAN_ORDER_1[BIT_SCAN_POS] & TWO_BUTTON,
                       RST_SCAN_ORDER_0[BIT_SCAN_POS]};
      threshold_q  <= {TWO_BUTTON ? RST_THRESHOLD : 8'h00, RST_THRESHOLD};
      charge_q     <= {TWO_BUTTON ? RST_CHARGE : 8'h00, RST_CHARGE};
    end else if (ce_in && reg_wr_in) begin
      for (int s = 0; s < SENSORS; s++) begin
        if (exists[s]) begin
          if (setup_mode_in && reg_addr_in == OFS_SCAN_ORDER_0 + 8'(s)) begin
            scan_order_q[s] <= reg_wdata_in[BIT_SCAN_POS];
          end
          if (reg_addr_in == OFS_THRESHOLD_0 + 8'(s)) begin
            threshold_q[s] <= reg_wdata_in;
          end
          if (reg_addr_in == OFS_CHARGE_0 + 8'(s)) begin
            charge_q[s] <= (reg_wdata_in == CHARGE_ZERO) ? RST_CHARGE : reg_wdata_in;
          end
        end
      end
    end
  end

  assign charge_current_out = charge_q;

  // sensor with position 0 goes first; ties keep sensor 0 first
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      first_sensor_out <= 1'b0;
    end else if (ce_in) begin
      first_sensor_out <= TWO_BUTTON && (scan_order_q[1] < scan_order_q[0]);
    end
  end

  // lock sequence detector; a wrong byte restarts, a start byte re-arms
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      seq_q              <= TSCR_SEQ_IDLE;
      address_locked_out <= RST_LOCK_FLAG;
    end else if (lock_wr) begin
      seq_q <= TSCR_SEQ_IDLE;
      if (reg_wdata_in == UNLOCK_BYTE_0) begin
        seq_q <= TSCR_SEQ_UNL_1;
      end else if (reg_wdata_in == LOCK_BYTE_0) begin
        seq_q <= TSCR_SEQ_LCK_1;
      end
      unique case (seq_q)
        TSCR_SEQ_IDLE: begin
        end
        TSCR_SEQ_UNL_1: begin
          if (reg_wdata_in == UNLOCK_BYTE_1) begin
            seq_q <= TSCR_SEQ_UNL_2;
          end
        end
        TSCR_SEQ_UNL_2: begin
          if (reg_wdata_in == UNLOCK_BYTE_2) begin
            seq_q              <= TSCR_SEQ_IDLE;
            address_locked_out <= 1'b0;
          end
        end
        TSCR_SEQ_LCK_1: begin
          if (reg_wdata_in == LOCK_BYTE_1) begin
            seq_q <= TSCR_SEQ_LCK_2;
          end
        end
        TSCR_SEQ_LCK_2: begin
          if (reg_wdata_in == LOCK_BYTE_2) begin
            seq_q              <= TSCR_SEQ_IDLE;
            address_locked_out <= 1'b1;
          end
        end
        default: begin
          seq_q <= TSCR_SEQ_IDLE;
        end
      endcase
    end
  end

  // address staging; the active address follows only on relock
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      addr_pending_q  <= RST_BUS_ADDRESS;
      bus_address_out <= RST_BUS_ADDRESS;
    end else if (ce_in) begin
      if (reg_wr_in && reg_addr_in == OFS_BUS_ADDRESS && !address_locked_out) begin
        addr_pending_q <= reg_wdata_in;
      end
      if (lock_wr && seq_q == TSCR_SEQ_LCK_2 && reg_wdata_in == LOCK_BYTE_2) begin
        bus_address_out <= addr_pending_q;
      end
    end
  end

  // read path, one cycle latency
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr_in)
      OFS_FILTER_CTRL:  rdata_d = filter_q;
      OFS_SCAN_ORDER_0: rdata_d = {7'h00, scan_order_q[0]};
      OFS_SCAN_ORDER_1: rdata_d = {7'h00, scan_order_q[1] & TWO_BUTTON};
      OFS_THRESHOLD_0:  rdata_d = threshold_q[0];
      OFS_THRESHOLD_1:  rdata_d = TWO_BUTTON ? threshold_q[1] : 8'h00;
      OFS_CHARGE_0:     rdata_d = charge_q[0];
      OFS_CHARGE_1:     rdata_d = TWO_BUTTON ? charge_q[1] : 8'h00;
      OFS_ADDR_GUARD:   rdata_d = {7'h00, address_locked_out};
      OFS_BUS_ADDRESS:  rdata_d = addr_pending_q;
      default:          rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else if (ce_in) begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

  // bus activity seen since the scan began; activity wins over restart
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bus_seen_q <= 1'b0;
    end else if (ce_in) begin
      if (bus_active_in) begin
        bus_seen_q <= 1'b1;
      end else if (scan_start_in) begin
        bus_seen_q <= 1'b0;
      end
    end
  end

  assign sample_ok = sample_valid_in &&
                     !(filter_q[BIT_DROP_ON_BUS] && (bus_seen_q || bus_active_in));

  tscr_sample_if smp [SENSORS] ();

  for (genvar s = 0; s < SENSORS; s++) begin : g_sensor
    assign smp[s].valid  = sample_ok && exists[s] && (sample_sensor_in == 1'(s));
    assign smp[s].count  = raw_count_in;
    assign smp[s].avg_en = filter_q[BIT_AVG_ENABLE];
    assign smp[s].order  = filter_q[BIT_ORDER_HI:BIT_ORDER_LO];
    assign smp[s].clear  = baseline_clear_out;

    tscr_avg u_avg (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n_in),
      .ce_in     (ce_in),
      .smp       (smp[s]),
      .valid_out (avg_valid_out[s]),
      .count_out (avg_count_out[s])
    );

    logic [15:0] upper;
    logic [15:0] lower;
    assign upper = {8'h00, threshold_q[s]} + {8'h00, hysteresis_in};
    assign lower = (threshold_q[s] > hysteresis_in) ?
                   {8'h00, threshold_q[s] - hysteresis_in} : 16'h0000;

    always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
        touch_active_out[s] <= 1'b0;
      end else if (ce_in) begin
        if (!exists[s] || baseline_clear_out) begin
          touch_active_out[s] <= 1'b0;
        end else if (!touch_active_out[s] && diff_count_in[s] > upper) begin
          touch_active_out[s] <= 1'b1;
        end else if (touch_active_out[s] && diff_count_in[s] < lower) begin
          touch_active_out[s] <= 1'b0;
        end
      end
    end

    touch_on_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      ce_in && exists[s] && !baseline_clear_out && !touch_active_out[s]
      && diff_count_in[s] > upper |=> touch_active_out[s])
      else $error("touch not detected above threshold plus hysteresis");
  end

  sequence guard_wr(logic [7:0] b);
    ce_in && reg_wr_in && reg_addr_in == OFS_ADDR_GUARD && reg_wdata_in == b;
  endsequence

  sequence unlock_seq;
    guard_wr(UNLOCK_BYTE_0) ##1 guard_wr(UNLOCK_BYTE_1) ##1 guard_wr(UNLOCK_BYTE_2);
  endsequence

  sequence lock_seq;
    guard_wr(LOCK_BYTE_0) ##1 guard_wr(LOCK_BYTE_1) ##1 guard_wr(LOCK_BYTE_2);
  endsequence

  baseline_pulse_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && reg_wr_in && reg_addr_in == OFS_FILTER_CTRL && reg_wdata_in[BIT_BASELINE_CLEAR]
    |=> baseline_clear_out && filter_q[BIT_BASELINE_CLEAR] ##1
        (!$past(ce_in) || !filter_q[BIT_BASELINE_CLEAR] ||
         $past(reg_wr_in && reg_addr_in == OFS_FILTER_CTRL && reg_wdata_in[BIT_BASELINE_CLEAR])))
    else $error("baseline clear not pulsed or not self-cleared");

  drop_sample_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    filter_q[BIT_DROP_ON_BUS] && bus_active_in |-> !smp[0].valid && !smp[1].valid)
    else $error("sample kept during bus activity");

  scan_setup_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !setup_mode_in |=> $stable(scan_order_q))
    else $error("scan order changed outside setup mode");

  charge_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && reg_wr_in && reg_addr_in == OFS_CHARGE_0 && reg_wdata_in == CHARGE_ZERO
    |=> charge_current_out[0] == RST_CHARGE)
    else $error("zero charge current not replaced by default");

  unlock_seq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    unlock_seq |=> !address_locked_out)
    else $error("unlock sequence did not unlock");

  lock_seq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    lock_seq |=> address_locked_out && bus_address_out == $past(addr_pending_q))
    else $error("lock sequence did not lock and apply address");

  lock_only_seq_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $changed(address_locked_out) |-> $past(lock_wr) && $past(seq_q) inside
      {TSCR_SEQ_UNL_2, TSCR_SEQ_LCK_2})
    else $error("lock state changed without full sequence");

  locked_ignore_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    address_locked_out |=> $stable(addr_pending_q))
    else $error("address written while locked");

  lock_read_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ce_in && reg_rd_in && reg_addr_in == OFS_ADDR_GUARD
    |=> reg_rvalid_out && reg_rdata_out == {7'h00, $past(address_locked_out)})
    else $error("lock register read wrong");

endmodule : tscr_regs

// file: tb/tscr_host.sv
/*
  tscr_host: serial host model driving the register port of the bank.
  Assumes one clock; requests change at the falling edge only.
*/
`timescale 1ns/1ps
module tscr_host (
  input  wire logic       clk_in,        // system clock
  input  wire logic [7:0] reg_rdata_in,  // read byte
  input  wire logic       reg_rvalid_in, // read valid
  output logic [7:0]      reg_addr_out,  // register offset
  output logic [7:0]      reg_wdata_out, // write byte
  output logic            reg_wr_out,    // write strobe
  output logic            reg_rd_out     // read strobe
);
  initial begin
    reg_addr_out  = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out    = 1'b0;
    reg_rd_out    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    reg_addr_out  = a;
    reg_wdata_out = d;
    reg_wr_out    = 1'b1;
    @(negedge clk_in);
    reg_wr_out    = 1'b0;
    reg_wdata_out = ~d;  // released data does not keep its last value
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_in);
    reg_addr_out = a;
    reg_rd_out   = 1'b1;
    @(negedge clk_in);
    reg_rd_out   = 1'b0;
    ok = (reg_rvalid_in === 1'b1);
    d  = reg_rdata_in;
  endtask : rd

  // three bytes in a row to the guard register
  task automatic seq(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
    @(negedge clk_in);
    reg_addr_out  = 8'h79;
    reg_wdata_out = b0;
    reg_wr_out    = 1'b1;
    @(negedge clk_in);
    reg_wdata_out = b1;
    @(negedge clk_in);
    reg_wdata_out = b2;
    @(negedge clk_in);
    reg_wr_out    = 1'b0;
    reg_wdata_out = ~b2;
  endtask : seq

  // common setup registers go first
  task automatic prep();
    wr(8'h07, 8'h00);
    wr(8'h50, 8'h00);
    wr(8'h51, 8'h00);
  endtask : prep
endmodule : tscr_host

// file: tb/tscr_regs_test.sv
/*
  tscr_regs_test: self-checking bench for the register bank.
  Assumes the host model drives the register port; samples driven here.
*/
`timescale 1ns/1ps
module tscr_regs_test;
  import tscr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, setup = 1'b0, bus = 1'b0, sstart = 1'b0;
  logic svalid = 1'b0, ssensor = 1'b0, rvalid, bclr, fsens, locked;
  logic [7:0] addr, wdata, rdata, hys = 8'h05, baddr, rb;
  logic wr, rd, ok;
  logic ce = 1'b1;
  logic [7:0] rdata1;
  logic [SENSORS-1:0][7:0] chg1;
  tscr_count_t raw = '0;
  logic [SENSORS-1:0][15:0] diff = '0, avgc;
  logic [SENSORS-1:0] avgv, touch;
  logic [SENSORS-1:0][7:0] chg;
  int errors = 0, checks_done = 0;
  logic [7:0] rst_val [8] = '{8'h20, 8'h00, 8'h01, 8'h64, 8'h64, 8'h0a, 8'h0a, 8'h00};
  logic [7:0] rst_ofs [8] = '{8'h56, 8'h5c, 8'h5d, 8'h66, 8'h67, 8'h70, 8'h71, 8'h79};

  always #12.5 clk = ~clk;

  tscr_host host (.clk_in(clk), .reg_rdata_in(rdata), .reg_rvalid_in(rvalid),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd));
  tscr_regs #(.TWO_BUTTON(1'b0)) dut1 (.clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata1), .reg_rvalid_out(), .setup_mode_in(setup),
    .bus_active_in(bus), .scan_start_in(sstart), .sample_valid_in(svalid),
    .sample_sensor_in(ssensor), .raw_count_in(raw), .diff_count_in(diff),
    .hysteresis_in(hys), .baseline_clear_out(), .avg_valid_out(),
    .avg_count_out(), .touch_active_out(), .first_sensor_out(),
    .charge_current_out(chg1), .bus_address_out(), .address_locked_out());
  tscr_regs #(.TWO_BUTTON(1'b1)) dut (.clk_in(clk), .rst_n_in(rst_n), .ce_in(ce),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .setup_mode_in(setup),
    .bus_active_in(bus), .scan_start_in(sstart), .sample_valid_in(svalid),
    .sample_sensor_in(ssensor), .raw_count_in(raw), .diff_count_in(diff),
    .hysteresis_in(hys), .baseline_clear_out(bclr), .avg_valid_out(avgv),
    .avg_count_out(avgc), .touch_active_out(touch), .first_sensor_out(fsens),
    .charge_current_out(chg), .bus_address_out(baddr), .address_locked_out(locked));

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rb, ok);
    chk("rvalid", 16'h1, {15'h0, ok});
    chk($sformatf("reg %h", a), {8'h0, e}, {8'h0, rb});
  endtask : rdchk

  task automatic sample(input logic [15:0] c);
    @(negedge clk);
    svalid = 1'b1;
    raw    = c;
    @(negedge clk);
    svalid = 1'b0;
  endtask : sample

  task automatic t_reset();
    for (int i = 0; i < 8; i++) rdchk(rst_ofs[i], rst_val[i]);
    chk("first", 16'h0, {15'h0, fsens});
  endtask : t_reset

  task automatic t_charge();
    host.wr(8'h71, 8'h00);
    rdchk(8'h71, 8'h0a);
    chk("one-button reg 71", 16'h0, {8'h0, rdata1});
    chk("one-button chg", 16'h000a, {chg1[1], chg1[0]});
    host.wr(8'h70, 8'h05);
    rdchk(8'h70, 8'h05);
    chk("chg", 16'h0a05, {chg[1], chg[0]});
    ce = 1'b0;
    host.wr(8'h70, 8'h33);
    ce = 1'b1;
    rdchk(8'h70, 8'h05);
  endtask : t_charge

  task automatic t_scan();
    host.wr(8'h5c, 8'h01);
    rdchk(8'h5c, 8'h00);
    setup = 1'b1;
    host.wr(8'h5c, 8'h01);
    host.wr(8'h5d, 8'h00);
    setup = 1'b0;
    rdchk(8'h5c, 8'h01);
    chk("first", 16'h1, {15'h0, fsens});
  endtask : t_scan

  task automatic t_touch();
    host.wr(8'h67, 8'h20);
    rdchk(8'h67, 8'h20);
    rdchk(8'h66, 8'h64);
    diff[1] = 16'h0030;
    diff[0] = 16'h006a;
    repeat (2) @(negedge clk);
    chk("touch on", 16'h1, {15'h0, touch[0]});
    chk("touch 1 on", 16'h1, {15'h0, touch[1]});
    diff[0] = 16'h0060;
    repeat (2) @(negedge clk);
    chk("touch hold", 16'h1, {15'h0, touch[0]});
    diff[0] = 16'h005e;
    repeat (2) @(negedge clk);
    chk("touch off", 16'h0, {15'h0, touch[0]});
  endtask : t_touch

  task automatic t_avg();
    int pulses;
    for (int o = 0; o < 4; o++) begin
      host.wr(8'h56, 8'h10 | o[7:0]);
      pulses = 0;
      for (int s = 0; s < (2 << o); s++) begin
        sample(16'h0004 + s[15:0]);
        pulses += avgv[0];
      end
      chk("pulses", 16'h1, pulses[15:0]);
      chk("avg", 16'h0004 + ((2 << o) - 1) / 2, avgc[0]);
    end
    host.wr(8'h56, 8'h10);
    @(negedge clk);
    svalid = 1'b1;
    raw    = 16'h0010;
    @(negedge clk);
    raw    = 16'h0013;
    @(negedge clk);
    svalid = 1'b0;
    chk("pair pulse", 16'h1, {15'h0, avgv[0]});
    chk("pair avg", 16'h0011, avgc[0]);
  endtask : t_avg

  task automatic t_drop();
    host.wr(8'h56, 8'h20);
    @(negedge clk);
    sstart = 1'b1;
    bus    = 1'b1;
    @(negedge clk);
    sstart = 1'b0;
    bus    = 1'b0;
    sample(16'h0123);
    chk("dropped", 16'h0, {15'h0, avgv[0]});
    @(negedge clk);
    sstart = 1'b1;
    @(negedge clk);
    sstart = 1'b0;
    sample(16'h0321);
    chk("kept", 16'h1, {15'h0, avgv[0]});
    chk("raw", 16'h0321, avgc[0]);
    ssensor = 1'b1;
    sample(16'h0456);
    ssensor = 1'b0;
    chk("sensor 1 valid", 16'h1, {15'h0, avgv[1]});
    chk("sensor 1 raw", 16'h0456, avgc[1]);
  endtask : t_drop

  task automatic t_baseline();
    host.wr(8'h56, 8'h80);
    chk("clear pulse", 16'h1, {15'h0, bclr});
    @(negedge clk);
    chk("clear end", 16'h0, {15'h0, bclr});
    rdchk(8'h56, 8'h00);
  endtask : t_baseline

  task automatic t_lock();
    host.wr(8'h7c, 8'h42);
    chk("addr pending", 16'h0, {8'h0, baddr});
    host.seq(8'h96, 8'h5a, 8'hc3);
    chk("locked", 16'h1, {15'h0, locked});
    chk("addr used", 16'h42, {8'h0, baddr});
    host.wr(8'h7c, 8'h55);
    rdchk(8'h7c, 8'h42);
    host.seq(8'h3c, 8'h11, 8'h69);
    rdchk(8'h79, 8'h01);
    host.seq(8'h3c, 8'ha5, 8'h69);
    rdchk(8'h79, 8'h00);
  endtask : t_lock

  task automatic print_verdict();
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    host.prep();
    t_reset();
    t_charge();
    t_scan();
    t_touch();
    t_avg();
    t_drop();
    t_baseline();
    t_lock();
    print_verdict();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict();
  end
endmodule : tscr_regs_test
